// File: sas_defines.vh
// Constants for the converter sequencer: register offsets, field positions,
// reset values and cycle counts in converter clock periods.
// Assumes inclusion by bare name from every design file of the block.
`ifndef SAS_DEFINES_VH
`define SAS_DEFINES_VH

// Register offsets on the plain register port
`define SAS_OFS_RESULT_LOW 8'h04
`define SAS_OFS_RESULT_HIGH 8'h05
`define SAS_OFS_CTRL_STATUS 8'h06
`define SAS_OFS_CHANNEL 8'h07

// Control, status and channel field positions
`define SAS_BIT_ENABLE 7
`define SAS_BIT_START 6
`define SAS_BIT_DONE_FLAG 4
`define SAS_BIT_IRQ_EN 3
`define SAS_DIV_MSB 2
`define SAS_DIV_LSB 0
`define SAS_CHAN_MSB 2
`define SAS_CHAN_LSB 0

// Reset values
`define SAS_RST_DIV 3'h0
`define SAS_RST_CHAN 3'h0
`define SAS_RST_RESULT 10'h000
`define SAS_ZERO_BYTE 8'h00

// Conversion timing in converter clock cycles, counted from the start edge
`define SAS_DUMMY_CYCLES 5'h0D
`define SAS_NO_DUMMY 5'h00
`define SAS_SAMPLE_CYC 5'h01
`define SAS_RESULT_CYC 5'h0D
`define SAS_TOTAL_CYC 5'h0F

// Prescaler width and result layout
`define SAS_PRESC_W 7
`define SAS_PRESC_ZERO 7'h00
`define SAS_PRESC_ONE 7'h01
`define SAS_RES_HIGH_PAD 6'h00

`endif

// File: sas_prescaler.v
// Converter clock prescaler: free counter on sys_clk, divide by 2 to 128.
// Assumes enable and divider select come from the control register.
`default_nettype none
`include "sas_defines.vh"

module sas_prescaler (
   input wire sys_clk,
   input wire rst,
   input wire conv_enable,
   input wire [2:0] clock_divider_select,
   output reg conv_clk,
   output wire fall_tick
);

   reg [`SAS_PRESC_W-1:0] count;

   // Mask of the counter bits below the selected clock bit; code 0 gives none
   function [`SAS_PRESC_W-1:0] div_mask;
      input [2:0] code;
      begin
         div_mask = (`SAS_PRESC_ONE << code) - `SAS_PRESC_ONE;
      end
   endfunction

   // Counter held in reset while disabled, runs from the enable onward
   always @(posedge sys_clk) begin
      if (rst || !conv_enable) begin
         count <= `SAS_PRESC_ZERO;
         conv_clk <= 1'b0;
      end else begin
         count <= count + `SAS_PRESC_ONE;
         conv_clk <= (count & div_mask(clock_divider_select)) >=
                     ((div_mask(clock_divider_select) >> 1) + `SAS_PRESC_ONE) ? 1'b0 : 1'b1;
      end
   end

   // Falling edge of the converter clock; invalid code 0 never ticks
   assign fall_tick = conv_enable && (clock_divider_select != `SAS_RST_DIV) &&
                      ((count & div_mask(clock_divider_select)) == div_mask(clock_divider_select));

endmodule // sas_prescaler
`default_nettype wire

// File: sas_result_lock.v
// Result byte pair with read protection between low and high byte reads.
// Assumes one-cycle strobes for result write and for each byte read.
`default_nettype none
`include "sas_defines.vh"

module sas_result_lock (
   input wire sys_clk,
   input wire rst,
   input wire result_write,
   input wire [9:0] result_in,
   input wire rd_low,
   input wire rd_high,
   output wire [7:0] result_low_byte,
   output wire [7:0] result_high_byte,
   output reg locked
);

   reg [9:0] result;

   // A write in the same cycle as the low read is dropped, so the pair stays whole
   always @(posedge sys_clk) begin
      if (rst) begin
         result <= `SAS_RST_RESULT;
         locked <= 1'b0;
      end else begin
         if (result_write && !locked && !rd_low)
            result <= result_in;
         if (rd_low)
            locked <= 1'b1;
         else if (rd_high)
            locked <= 1'b0;
      end
   end

   assign result_low_byte = result[7:0];
   assign result_high_byte = {`SAS_RES_HIGH_PAD, result[9:8]};

endmodule // sas_result_lock
`default_nettype wire

// File: sas_sequencer.v
// Control of an 8-input 10-bit successive approximation converter: register
// port, prescaler, single-conversion sequencing, result protection, interrupt.
// Assumes a synchronous register port and an analog core that presents its
// 10-bit result on core_result in the capture cycle, one cycle before the result strobe.
//
// Added by the designer: the address-and-strobe port.
`default_nettype none
`include "sas_defines.vh"

module sas_sequencer (
   input wire sys_clk,
   input wire rst,
   input wire [7:0] bus_addr,
   input wire [7:0] bus_wdata,
   input wire bus_wr,
   input wire bus_rd,
   output reg [7:0] bus_rdata,
   input wire global_irq_en,
   input wire irq_vector_ack,
   output wire conv_done_irq,
   input wire [9:0] core_result,
   output wire core_power,
   output wire core_clk,
   output reg core_busy,
   output reg core_dummy,
   output reg sample_hold_strobe,
   output reg result_strobe,
   output reg [2:0] analog_channel
);

   // Sequencer states
   localparam ST_IDLE = 2'h0;
   localparam ST_CONV = 2'h1;
   localparam ST_GAP = 2'h2;

   // Software-visible control bits
   reg conv_enable;
   reg conv_start;
   reg conv_done_flag;
   reg conv_done_irq_en;
   reg [2:0] clock_divider_select;
   reg [2:0] channel_code;

   // Sequencer state
   reg [1:0] state;
   reg [4:0] cyc;
   reg dummy_run;
   reg first_pending;

   wire fall_tick;
   wire locked;
   wire [7:0] result_low_byte;
   wire [7:0] result_high_byte;

   // Bus decode
   wire wr_ctrl = bus_wr && (bus_addr == `SAS_OFS_CTRL_STATUS);
   wire wr_chan = bus_wr && (bus_addr == `SAS_OFS_CHANNEL);
   wire rd_low = bus_rd && (bus_addr == `SAS_OFS_RESULT_LOW);
   wire rd_high = bus_rd && (bus_addr == `SAS_OFS_RESULT_HIGH);

   // Offset added to every event while the dummy phase precedes the real one
   wire [4:0] off = dummy_run ? `SAS_DUMMY_CYCLES : `SAS_NO_DUMMY;
   wire [4:0] nxt_cyc = cyc + 5'h01;

   // Events on the converter clock falling edge
   wire at_sample = fall_tick && (state == ST_CONV) && (nxt_cyc == off + `SAS_SAMPLE_CYC);
   wire at_result = fall_tick && (state == ST_CONV) && (nxt_cyc == off + `SAS_RESULT_CYC);
   wire at_gap_end = fall_tick && (state == ST_GAP) && (nxt_cyc == off + `SAS_TOTAL_CYC);
   wire launch = fall_tick && conv_start && conv_enable &&
                 ((state == ST_IDLE) || at_gap_end);

   // Enable alone powers the analog core
   assign core_power = conv_enable;

   sas_prescaler u_prescaler (
      .sys_clk(sys_clk),
      .rst(rst),
      .conv_enable(conv_enable),
      .clock_divider_select(clock_divider_select),
      .conv_clk(core_clk),
      .fall_tick(fall_tick)
   );

   sas_result_lock u_result_lock (
      .sys_clk(sys_clk),
      .rst(rst),
      .result_write(at_result),
      .result_in(core_result),
      .rd_low(rd_low),
      .rd_high(rd_high),
      .result_low_byte(result_low_byte),
      .result_high_byte(result_high_byte),
      .locked(locked)
   );

   // Plain control bits written by software
   always @(posedge sys_clk) begin
      if (rst) begin
         conv_enable <= 1'b0;
         conv_done_irq_en <= 1'b0;
         clock_divider_select <= `SAS_RST_DIV;
         channel_code <= `SAS_RST_CHAN;
      end else begin
         if (wr_ctrl) begin
            conv_enable <= bus_wdata[`SAS_BIT_ENABLE];
            conv_done_irq_en <= bus_wdata[`SAS_BIT_IRQ_EN];
            clock_divider_select <= bus_wdata[`SAS_DIV_MSB:`SAS_DIV_LSB];
         end
         if (wr_chan)
            channel_code <= bus_wdata[`SAS_CHAN_MSB:`SAS_CHAN_LSB];
      end
   end

   // Start bit: set by a written one, cleared at result or by disable
   always @(posedge sys_clk) begin
      if (rst) begin
         conv_start <= 1'b0;
      end else if (wr_ctrl && !bus_wdata[`SAS_BIT_ENABLE]) begin
         conv_start <= 1'b0;
      end else if (wr_ctrl && bus_wdata[`SAS_BIT_START]) begin
         conv_start <= 1'b1;
      end else if (at_result) begin
         conv_start <= 1'b0;
      end
   end

   // Done flag: set wins over both clears
   always @(posedge sys_clk) begin
      if (rst) begin
         conv_done_flag <= 1'b0;
      end else if (at_result) begin
         conv_done_flag <= 1'b1;
      end else if (irq_vector_ack || (wr_ctrl && bus_wdata[`SAS_BIT_DONE_FLAG])) begin
         conv_done_flag <= 1'b0;
      end
   end

   // Dummy request is armed every cycle the converter is off
   always @(posedge sys_clk) begin
      if (rst) begin
         first_pending <= 1'b1;
      end else if (!conv_enable) begin
         first_pending <= 1'b1;
      end else if (launch) begin
         first_pending <= 1'b0;
      end
   end

   // Conversion sequencer, stepped only on converter clock falls
   always @(posedge sys_clk) begin
      if (rst) begin
         state <= ST_IDLE;
         cyc <= 5'h00;
         dummy_run <= 1'b0;
         analog_channel <= `SAS_RST_CHAN;
      end else if (!conv_enable || (wr_ctrl && !bus_wdata[`SAS_BIT_ENABLE])) begin
         state <= ST_IDLE;
         cyc <= 5'h00;
         dummy_run <= 1'b0;
      end else if (launch) begin
         state <= ST_CONV;
         cyc <= 5'h00;
         dummy_run <= first_pending;
         analog_channel <= channel_code;
      end else if (fall_tick) begin
         case (state)
            ST_CONV: begin
               cyc <= nxt_cyc;
               if (at_result)
                  state <= ST_GAP;
            end
            ST_GAP: begin
               cyc <= nxt_cyc;
               if (at_gap_end)
                  state <= ST_IDLE;
            end
            default: begin
               cyc <= 5'h00;
            end
         endcase
      end
   end

   // Outputs to the analog core: strobes one sys_clk long, busy and dummy as levels
   always @(posedge sys_clk) begin
      if (rst) begin
         sample_hold_strobe <= 1'b0;
         result_strobe <= 1'b0;
         core_busy <= 1'b0;
         core_dummy <= 1'b0;
      end else begin
         sample_hold_strobe <= at_sample;
         result_strobe <= at_result;
         core_busy <= (state != ST_IDLE);
         core_dummy <= dummy_run && (state == ST_CONV) && (cyc < `SAS_DUMMY_CYCLES);
      end
   end

   // Interrupt request keeps working in idle, so it can wake the processor
   assign conv_done_irq = conv_done_flag && conv_done_irq_en && global_irq_en;

   // Read data one cycle after the strobe; unmapped reads return zero
   always @(posedge sys_clk) begin
      if (rst) begin
         bus_rdata <= `SAS_ZERO_BYTE;
      end else if (bus_rd) begin
         if (bus_addr == `SAS_OFS_CTRL_STATUS)
            bus_rdata <= {conv_enable, conv_start, 1'b0, conv_done_flag, conv_done_irq_en,
                          clock_divider_select};
         else if (bus_addr == `SAS_OFS_CHANNEL)
            bus_rdata <= {5'h00, channel_code};
         else if (bus_addr == `SAS_OFS_RESULT_LOW)
            bus_rdata <= result_low_byte;
         else if (bus_addr == `SAS_OFS_RESULT_HIGH)
            bus_rdata <= result_high_byte;
         else
            bus_rdata <= `SAS_ZERO_BYTE;
      end else begin
         bus_rdata <= `SAS_ZERO_BYTE;
      end
   end

endmodule // sas_sequencer
`default_nettype wire

// File: sas_seq_properties.sv
// Checker for the converter sequencer, bound to its top module.
// Assumes only the top module's ports are visible.
`default_nettype none
module sas_seq_properties (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic bus_rd,
   input wire logic [7:0] bus_rdata,
   input wire logic global_irq_en,
   input wire logic conv_done_irq,
   input wire logic core_power,
   input wire logic core_clk,
   input wire logic core_busy,
   input wire logic core_dummy,
   input wire logic sample_hold_strobe,
   input wire logic result_strobe,
   input wire logic [2:0] analog_channel
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // Request gated by the processor enable
   chk_irq_gated: assert property (conv_done_irq |-> global_irq_en)
      else $error("irq without global enable");
   // Disabled converter never runs
   // Busy is registered from the old state, so it may lag the disable by one cycle
   chk_off_idle: assert property (!core_power && $past(!core_power) |-> !core_busy)
      else $error("busy while disabled");
   // Prescaler held while disabled
   chk_clk_held: assert property (!core_power && $past(!core_power) |-> !core_clk)
      else $error("converter clock runs while disabled");
   chk_sample_run: assert property (sample_hold_strobe |-> core_busy)
      else $error("sample outside a conversion");
   chk_result_pulse: assert property (result_strobe |=> !result_strobe)
      else $error("result strobe longer than one cycle");
   // Channel frozen for 8 cycles after the hold strobe
   chk_chan_hold: assert property (sample_hold_strobe |=> $stable(analog_channel) [*8])
      else $error("channel moved mid conversion");
   chk_dummy_run: assert property (core_dummy |-> core_busy)
      else $error("dummy phase outside a conversion");
   // Read data only in the cycle after a read
   chk_rdata_idle: assert property (!$past(bus_rd) |-> bus_rdata == 8'h00)
      else $error("read data outside its cycle");
   chk_result_gap: assert property (result_strobe |-> core_busy)
      else $error("result after the gap");
   cover property (core_dummy && sample_hold_strobe);
   cover property ($fell(core_busy));
   cover property (conv_done_irq);
endmodule // sas_seq_properties
`default_nettype wire

// File: sas_core_model.sv
// Analog core model: holds the level sampled on the hold strobe.
// Assumes sequencer outputs on the same system clock.
`default_nettype none
module sas_core_model (
   input wire logic sys_clk,
   input wire logic core_power,
   input wire logic sample_hold_strobe,
   input wire logic [2:0] analog_channel,
   output logic [9:0] core_result
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [9:0] held;
   initial begin
      held = 10'h000;
      core_result = 10'h000;
   end
   // Level encodes the channel sampled, so a late switch shows
   always @(posedge sys_clk) begin
      if (sample_hold_strobe) begin
         held <= {analog_channel, 7'h2A};
      end
      core_result <= core_power ? held : ~core_result; // Unpowered: no stale value
   end
endmodule // sas_core_model
`default_nettype wire

// File: tb_sas_sequencer.sv
// Directed tests of the converter sequencer over its register port.
// Assumes the core model and checker are compiled before this file.
`default_nettype none
`include "sas_defines.vh"
module tb_sas_sequencer;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, rst, bus_wr, bus_rd, global_irq_en, irq_vector_ack;
   logic [7:0] bus_addr, bus_wdata, rd_val;
   logic [15:0] span;
   wire [7:0] bus_rdata;
   wire [9:0] core_result;
   wire [2:0] analog_channel;
   wire conv_done_irq, core_power, core_clk, core_busy, core_dummy, sample_hold_strobe, result_strobe;
   int n_fail = 0;
   int cmp_count = 0;
   int c;
   sas_sequencer DUT (.sys_clk(sys_clk), .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .global_irq_en(global_irq_en),
      .irq_vector_ack(irq_vector_ack), .conv_done_irq(conv_done_irq), .core_result(core_result),
      .core_power(core_power), .core_clk(core_clk), .core_busy(core_busy), .core_dummy(core_dummy),
      .sample_hold_strobe(sample_hold_strobe), .result_strobe(result_strobe), .analog_channel(analog_channel));
   sas_core_model core (.sys_clk(sys_clk), .core_power(core_power), .sample_hold_strobe(sample_hold_strobe),
      .analog_channel(analog_channel), .core_result(core_result));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
   endtask
   // Data stands only in the cycle after the strobe
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1 rd_val = bus_rdata;
      chk("register read", {8'h00, exp}, {8'h00, rd_val});
   endtask
   // Start by control write, then time the busy span in system cycles
   task automatic conv(input logic [7:0] ctrl);
      int w;
      w = 0;
      wr(`SAS_OFS_CTRL_STATUS, ctrl);
      span = 16'h0000;
      while (!core_busy && w < 4000) begin
         @(posedge sys_clk);
         #1 w++;
      end
      while (core_busy && span < 16'h2000) begin
         @(posedge sys_clk);
         #1 span++;
      end
   endtask
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Hang guard, well past the longest expected run
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      test_done;
   end
   initial begin
      rst = 1'b1;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      bus_addr = 8'h00;
      bus_wdata = 8'h00;
      global_irq_en = 1'b0;
      irq_vector_ack = 1'b0;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      for (c = 4; c < 9; c++) rc(c[7:0], 8'h00);
      wr(`SAS_OFS_CHANNEL, 8'hFB);
      rc(`SAS_OFS_CHANNEL, 8'h03);
      // Enable only, with start written as zero
      wr(`SAS_OFS_CTRL_STATUS, 8'h81);
      repeat (40) @(posedge sys_clk);
      chk("idle busy", 16'h0000, {15'h0000, core_busy});
      // Channel switch and start-bit read while running
      fork
         begin
            @(posedge core_busy);
            wr(`SAS_OFS_CHANNEL, 8'h06);
            rc(`SAS_OFS_CTRL_STATUS, 8'hC1);
         end
      join_none
      conv(8'hC1);
      chk("first span", 16'd56, span);
      rc(`SAS_OFS_CTRL_STATUS, 8'h91);
      rc(`SAS_OFS_RESULT_LOW, 8'hAA);
      rc(`SAS_OFS_RESULT_HIGH, 8'h01);
      wr(`SAS_OFS_CTRL_STATUS, 8'h81);
      rc(`SAS_OFS_CTRL_STATUS, 8'h91);
      wr(`SAS_OFS_CTRL_STATUS, 8'h91);
      rc(`SAS_OFS_CTRL_STATUS, 8'h81);
      conv(8'hC1);
      chk("normal span", 16'd30, span);
      // Lock between byte reads drops the next result
      rc(`SAS_OFS_RESULT_LOW, 8'h2A);
      wr(`SAS_OFS_CHANNEL, 8'h05);
      conv(8'hD1);
      rc(`SAS_OFS_CTRL_STATUS, 8'h91);
      rc(`SAS_OFS_RESULT_HIGH, 8'h03);
      conv(8'hD1);
      rc(`SAS_OFS_RESULT_LOW, 8'hAA);
      rc(`SAS_OFS_RESULT_HIGH, 8'h02);
      // Interrupt request masking and vector clear
      wr(`SAS_OFS_CTRL_STATUS, 8'h89);
      #1 chk("irq masked", 16'h0000, {15'h0000, conv_done_irq});
      @(posedge sys_clk);
      global_irq_en <= 1'b1;
      @(posedge sys_clk);
      #1 chk("irq raised", 16'h0001, {15'h0000, conv_done_irq});
      @(posedge sys_clk);
      irq_vector_ack <= 1'b1;
      @(posedge sys_clk);
      irq_vector_ack <= 1'b0;
      #1 chk("irq cleared", 16'h0000, {15'h0000, conv_done_irq});
      rc(`SAS_OFS_CTRL_STATUS, 8'h89);
      // Start set in the gap chains straight on
      fork
         begin
            @(posedge result_strobe);
            wr(`SAS_OFS_CTRL_STATUS, 8'hCA);
         end
      join_none
      conv(8'hCA);
      chk("chained span", 16'd120, span);
      // Disable mid conversion, then the dummy phase returns
      fork
         begin
            @(posedge sample_hold_strobe);
            wr(`SAS_OFS_CTRL_STATUS, 8'h01);
         end
      join_none
      conv(8'hD1);
      rc(`SAS_OFS_CTRL_STATUS, 8'h01);
      conv(8'hC1);
      chk("rearmed span", 16'd56, span);
      // Every divider code from 1 to 7 in turn; real software keeps 50 to 200 kHz
      for (c = 1; c < 8; c++) begin
         conv(8'hD0 | c[7:0]);
         chk("divider span", 16'd15 << c, span);
      end
      test_done;
   end
endmodule // tb_sas_sequencer
bind sas_sequencer sas_seq_properties CHK (.sys_clk(sys_clk), .rst(rst), .bus_rd(bus_rd),
   .bus_rdata(bus_rdata), .global_irq_en(global_irq_en), .conv_done_irq(conv_done_irq),
   .core_power(core_power), .core_clk(core_clk), .core_busy(core_busy), .core_dummy(core_dummy),
   .sample_hold_strobe(sample_hold_strobe), .result_strobe(result_strobe), .analog_channel(analog_channel));
`default_nettype wire
